//--- pkg/iowd_map.vh
// Constants for the I/O window decode configuration registers.
// Included by the decode block and its window comparator; definitions only.
`ifndef IOWD_MAP_VH
`define IOWD_MAP_VH

// Configuration dword offsets (byte addresses)
`define IOWD_OFS_WIN0_BASE 8'h2C
`define IOWD_OFS_WIN0_LIMIT 8'h30
`define IOWD_OFS_WIN1_BASE 8'h34
`define IOWD_OFS_WIN1_LIMIT 8'h38
`define IOWD_OFS_INTR 8'h3C
// Byte offsets of the interrupt bytes inside the 3Ch dword
`define IOWD_OFS_INTR_LINE 8'h3C
`define IOWD_OFS_INTR_PIN 8'h3D

// Field layout of base and limit registers
`define IOWD_PAGE_MSB 31
`define IOWD_PAGE_LSB 16
`define IOWD_ADDR_MSB 15
`define IOWD_ADDR_LSB 2
`define IOWD_ADDR_W 14
`define IOWD_TYPE_W 2
`define IOWD_TYPE_IO32 2'h1
`define IOWD_PAGE_VAL 16'h0000

// Reset and fixed values
`define IOWD_ADDR_RST 14'h0000
`define IOWD_LINE_RST 8'h00
`define IOWD_PIN_VAL 8'h01

// ISA alias filter: address bits 9:8 nonzero marks upper 768 bytes of each 1K
`define IOWD_ISA_MSB 9
`define IOWD_ISA_LSB 8

`endif

//--- rtl/iowd_win_cmp.v
// One I/O window comparator: inclusive dword range check within page zero.
// Assumes base and limit fields arrive from registers in the same clock domain.
`timescale 1ns/10ps
`include "iowd_map.vh"

module iowd_win_cmp (
    input wire [31:0] i_addr,                  // I/O address under test
    input wire [`IOWD_ADDR_W-1:0] i_base,      // Window bottom, dword units
    input wire [`IOWD_ADDR_W-1:0] i_limit,     // Window top, dword units
    output wire o_hit                          // Address falls inside enabled window
);

    wire [`IOWD_ADDR_W-1:0] addr_dw;
    wire page_ok;
    wire win_enabled;

    assign addr_dw = i_addr[`IOWD_ADDR_MSB:`IOWD_ADDR_LSB];
    // Page field is fixed at zero, so only page zero decodes
    assign page_ok = (i_addr[`IOWD_PAGE_MSB:`IOWD_PAGE_LSB] == `IOWD_PAGE_VAL);
    assign win_enabled = (i_base != `IOWD_ADDR_RST) || (i_limit != `IOWD_ADDR_RST);
    assign o_hit = win_enabled && page_ok && (addr_dw >= i_base) && (addr_dw <= i_limit);

endmodule

//--- rtl/iowd_decode_regs.v
// I/O window decode registers of a PCI to CardBus bridge, with decode.
// Assumes configuration accesses and bus address probes are synchronous to i_mclk.
`timescale 1ns/10ps
`include "iowd_map.vh"

module iowd_decode_regs #(
    parameter NUM_WIN = 2                       // Number of I/O windows
) (
    input wire i_mclk,                          // PCI clock, 20 MHz
    input wire i_rst_n,                         // Asynchronous reset, active low
    input wire i_cfg_wr,                        // Config write strobe, one cycle
    input wire i_cfg_rd,                        // Config read strobe, one cycle
    input wire [7:0] i_cfg_addr,                // Config byte offset, dword aligned
    input wire [3:0] i_cfg_be,                  // Byte enables, active high
    input wire [31:0] i_cfg_wdata,              // Config write data
    output reg [31:0] o_cfg_rdata,              // Config read data
    output reg o_cfg_ack,                       // Access completed, one cycle
    input wire i_pci_io_req,                    // PCI I/O cycle address valid
    input wire [31:0] i_pci_io_addr,            // PCI I/O address
    output reg o_fwd_to_cb,                     // Forward PCI cycle to CardBus
    input wire i_cb_io_req,                     // CardBus I/O cycle address valid
    input wire [31:0] i_cb_io_addr,             // CardBus I/O address
    output reg o_fwd_to_pci,                    // Forward CardBus cycle to PCI
    input wire i_legacy_io_alias_filter,        // ISA alias filtering enabled
    input wire i_functional_irq_route_select,   // 0 PCI interrupt, 1 legacy steering
    input wire i_card_func_irq,                 // Card functional interrupt, high
    output reg o_pci_inta,                      // Interrupt toward PCI, active high
    output reg o_legacy_irq                     // Interrupt toward legacy steering
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    reg [`IOWD_ADDR_W-1:0] base_reg [0:NUM_WIN-1];
    reg [`IOWD_ADDR_W-1:0] limit_reg [0:NUM_WIN-1];
    reg [7:0] line_reg;
    reg [31:0] rdata_next;

    wire [NUM_WIN-1:0] pci_hit;
    wire [NUM_WIN-1:0] cb_hit;
    wire isa_alias;

    // Writable dword field assembled from byte lanes 0 and 1
    function [`IOWD_ADDR_W-1:0] merge_field;
        input [`IOWD_ADDR_W-1:0] old_val;
        input [3:0] be;
        input [31:0] wdata;
        reg [15:0] tmp;
        begin
            tmp = {old_val, `IOWD_TYPE_IO32};
            if (be[0]) begin
                tmp[7:0] = wdata[7:0];
            end
            if (be[1]) begin
                tmp[15:8] = wdata[15:8];
            end
            merge_field = tmp[`IOWD_ADDR_MSB:`IOWD_ADDR_LSB];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Per-window registers and comparators

    genvar gi;
    generate
        for (gi = 0; gi < NUM_WIN; gi = gi + 1) begin : g_win
            // Offset sums are integer wide; keep the low byte on purpose
            localparam integer OFS_BASE_INT = `IOWD_OFS_WIN0_BASE + gi * 8;
            localparam integer OFS_LIMIT_INT = `IOWD_OFS_WIN0_LIMIT + gi * 8;
            wire [31:0] ofs_base_full;
            wire [31:0] ofs_limit_full;
            wire [7:0] ofs_base;
            wire [7:0] ofs_limit;
            assign ofs_base_full = OFS_BASE_INT;
            assign ofs_limit_full = OFS_LIMIT_INT;
            assign ofs_base = ofs_base_full[7:0];
            assign ofs_limit = ofs_limit_full[7:0];

            always @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    base_reg[gi] <= `IOWD_ADDR_RST;
                    limit_reg[gi] <= `IOWD_ADDR_RST;
                end else if (i_cfg_wr) begin
                    // Upper lanes are ignored: page field stays zero
                    if (i_cfg_addr == ofs_base) begin
                        base_reg[gi] <= merge_field(base_reg[gi], i_cfg_be, i_cfg_wdata);
                    end
                    if (i_cfg_addr == ofs_limit) begin
                        limit_reg[gi] <= merge_field(limit_reg[gi], i_cfg_be, i_cfg_wdata);
                    end
                end
            end

            iowd_win_cmp u_pci_cmp (
                .i_addr(i_pci_io_addr),
                .i_base(base_reg[gi]),
                .i_limit(limit_reg[gi]),
                .o_hit(pci_hit[gi])
            );

            iowd_win_cmp u_cb_cmp (
                .i_addr(i_cb_io_addr),
                .i_base(base_reg[gi]),
                .i_limit(limit_reg[gi]),
                .o_hit(cb_hit[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt line register

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            line_reg <= `IOWD_LINE_RST;
        end else if (i_cfg_wr && (i_cfg_addr == `IOWD_OFS_INTR) && i_cfg_be[0]) begin
            line_reg <= i_cfg_wdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path; unmapped offsets and the bridge control half read zero

    integer k;
    always @* begin
        rdata_next = 32'h00000000;
        for (k = 0; k < NUM_WIN; k = k + 1) begin
            if (i_cfg_addr == (`IOWD_OFS_WIN0_BASE + k * 8)) begin
                rdata_next = {`IOWD_PAGE_VAL, base_reg[k], `IOWD_TYPE_IO32};
            end
            if (i_cfg_addr == (`IOWD_OFS_WIN0_LIMIT + k * 8)) begin
                rdata_next = {`IOWD_PAGE_VAL, limit_reg[k], `IOWD_TYPE_IO32};
            end
        end
        if (i_cfg_addr == `IOWD_OFS_INTR) begin
            rdata_next = {16'h0000, `IOWD_PIN_VAL, line_reg};
        end
    end

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cfg_rdata <= 32'h00000000;
            o_cfg_ack <= 1'b0;
        end else begin
            o_cfg_ack <= i_cfg_wr | i_cfg_rd;
            if (i_cfg_rd) begin
                o_cfg_rdata <= rdata_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Forwarding decisions and interrupt routing

    // Aliases of the ISA range sit in the upper three quarters of each 1K block
    assign isa_alias = (i_pci_io_addr[`IOWD_ISA_MSB:`IOWD_ISA_LSB] != 2'h0);

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fwd_to_cb <= 1'b0;
            o_fwd_to_pci <= 1'b0;
            o_pci_inta <= 1'b0;
            o_legacy_irq <= 1'b0;
        end else begin
            o_fwd_to_cb <= i_pci_io_req && (|pci_hit)
                && !(i_legacy_io_alias_filter && isa_alias);
            // Upstream decode is the inverse: cycles outside every window go to PCI
            o_fwd_to_pci <= i_cb_io_req && !(|cb_hit);
            o_pci_inta <= i_card_func_irq && !i_functional_irq_route_select;
            o_legacy_irq <= i_card_func_irq && i_functional_irq_route_select;
        end
    end

endmodule

//--- tb/iowd_chk_asserts.sv
// Port checker for the I/O window decode block.
// Assumes it is bound onto the block by tb.
`timescale 1ns/10ps
module iowd_chk (
    input wire i_mclk, i_rst_n, i_cfg_wr, i_cfg_rd, // Clock, reset, strobes
    input wire [7:0] i_cfg_addr, // Config offset
    input wire [31:0] o_cfg_rdata, i_pci_io_addr, // Read data, probe address
    input wire o_cfg_ack, i_pci_io_req, o_fwd_to_cb, // Completion and forward
    input wire i_legacy_io_alias_filter, i_functional_irq_route_select, // Controls
    input wire i_card_func_irq, o_pci_inta, o_legacy_irq // Interrupt path
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    property p_ack; (i_cfg_wr || i_cfg_rd) |=> o_cfg_ack; endproperty
    a_ack: assert property (p_ack) else $error("access not acked");
    property p_hold; !i_cfg_rd |=> $stable(o_cfg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_page; i_cfg_rd |=> o_cfg_rdata[31:16] == 16'h0000; endproperty
    a_page: assert property (p_page) else $error("page bits not zero");
    property p_type;
        i_cfg_rd && i_cfg_addr inside {8'h2C, 8'h30, 8'h34, 8'h38} |=> o_cfg_rdata[1:0] == 2'h1;
    endproperty
    a_type: assert property (p_type) else $error("type bits wrong");
    property p_pin; i_cfg_rd && i_cfg_addr == 8'h3C |=> o_cfg_rdata[15:8] == 8'h01; endproperty
    a_pin: assert property (p_pin) else $error("pin byte wrong");
    property p_off; i_pci_io_req && i_pci_io_addr[31:16] != 16'h0000 |=> !o_fwd_to_cb; endproperty
    a_off: assert property (p_off) else $error("hit outside page zero");
    property p_isa;
        i_pci_io_req && i_legacy_io_alias_filter && |i_pci_io_addr[9:8] |=> !o_fwd_to_cb;
    endproperty
    a_isa: assert property (p_isa) else $error("alias not filtered");
    property p_noreq; !i_pci_io_req |=> !o_fwd_to_cb; endproperty
    a_noreq: assert property (p_noreq) else $error("forward without cycle");
    property p_inta;
        i_card_func_irq && !i_functional_irq_route_select |=> o_pci_inta && !o_legacy_irq;
    endproperty
    a_inta: assert property (p_inta) else $error("pci route wrong");
    property p_quiet; !i_card_func_irq |=> !o_pci_inta && !o_legacy_irq; endproperty
    a_quiet: assert property (p_quiet) else $error("spurious interrupt");
endmodule

//--- tb/iowd_card.sv
// CardBus card model: presents I/O cycles and its function interrupt.
// Assumes tb tells it when to run a cycle.
`timescale 1ns/10ps
module iowd_card (
    input wire i_go, // Run an I/O cycle
    input wire [31:0] i_addr, // Cycle address
    input wire i_irq, // Interrupt wish
    output wire o_req, // Address valid
    output wire [31:0] o_addr, // Address toward bridge
    output wire o_irq // Interrupt level
);
    assign o_req = i_go;
    // Idle bus shows the inverted address, never a held address
    assign o_addr = i_go ? i_addr : ~i_addr;
    assign o_irq = i_irq;
endmodule

//--- tb/tb.sv
// Self-checking bench for the I/O window decode registers.
// Assumes the card model and checker files are compiled first.
`timescale 1ns/10ps
module tb;
    reg clk = 0, rst_n = 0, wr = 0, rd = 0, preq = 0, go = 0, flt = 0, sel = 0, irq = 0;
    reg [7:0] adr = 8'h00, line;
    reg [3:0] be = 4'h0;
    reg [31:0] wd = 32'h0, pa = 32'h0, ca = 32'h0, r;
    reg [13:0] fld [0:3];
    reg [7:0] ofs [0:7] = '{8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h00, 8'h28};
    reg [31:0] bnd [0:7] = '{32'h0FFC, 32'h1000, 32'h103C, 32'h1040, 32'h11000, 32'h07FC,
        32'h0800, 32'h0300};
    wire [31:0] rdata, cb_addr;
    wire ack, fcb, fpci, inta, leg, cb_req, cb_irq;
    integer error_cnt = 0, checks_done = 0, i;
    always #25 clk = ~clk;
    iowd_decode_regs i_iowd_decode_regs (.i_mclk(clk), .i_rst_n(rst_n), .i_cfg_wr(wr),
        .i_cfg_rd(rd), .i_cfg_addr(adr), .i_cfg_be(be), .i_cfg_wdata(wd), .o_cfg_rdata(rdata),
        .o_cfg_ack(ack), .i_pci_io_req(preq), .i_pci_io_addr(pa), .o_fwd_to_cb(fcb),
        .i_cb_io_req(cb_req), .i_cb_io_addr(cb_addr), .o_fwd_to_pci(fpci),
        .i_legacy_io_alias_filter(flt), .i_functional_irq_route_select(sel),
        .i_card_func_irq(cb_irq), .o_pci_inta(inta), .o_legacy_irq(leg));
    iowd_card i_iowd_card (.i_go(go), .i_addr(ca), .i_irq(irq), .o_req(cb_req),
        .o_addr(cb_addr), .o_irq(cb_irq));
    task chk(input string nm, input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("wrong value %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    function [31:0] mrd(input [7:0] a);
        begin
            mrd = 32'h0;
            if (a >= 8'h2C && a <= 8'h38)
                mrd = {16'h0000, fld[(a - 8'h2C) / 4], 2'h1};
            if (a == 8'h3C)
                mrd = {16'h0000, 8'h01, line};
        end
    endfunction
    task cfg(input w, input [7:0] a, input [3:0] b, input [31:0] d);
        begin
            @(negedge clk);
            {wr, rd, adr, be, wd} = {w, !w, a, b, d};
            @(negedge clk);
            {wr, rd} = 2'h0;
            chk("ack", ack, 1);
            if (w && a >= 8'h2C && a <= 8'h38) begin
                if (b[0]) fld[(a - 8'h2C) / 4][5:0] = d[7:2];
                if (b[1]) fld[(a - 8'h2C) / 4][13:6] = d[15:8];
            end
            if (w && a == 8'h3C && b[0]) line = d[7:0];
            if (!w) chk("rdata", rdata, mrd(a));
        end
    endtask
    task probe(input [31:0] a);
        integer k, hit;
        begin
            r = $urandom;
            {flt, sel, irq, pa, ca, preq, go, hit} = {r[2:0], a, a, 2'h3, 32'h0};
            for (k = 0; k < 4; k = k + 2)
                if (a[31:16] == 0 && (fld[k] != 0 || fld[k + 1] != 0) && a[15:2] >= fld[k]
                    && a[15:2] <= fld[k + 1]) hit = 1;
            @(negedge clk);
            chk("to_cb", fcb, hit && !(flt && a[9:8] != 0));
            chk("to_pci", fpci, !hit);
            chk("irq", {inta, leg}, {irq && !sel, irq && sel});
        end
    endtask
    task close_out;
        begin
            $display("checks %0d errors %0d", checks_done, error_cnt);
            if (error_cnt == 0 && checks_done > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        r = $urandom(38);
        {fld[0], fld[1], fld[2], fld[3], line} = 64'h0;
        repeat (5) @(posedge clk);
        @(negedge clk) rst_n = 1;
        for (i = 0; i < 8; i = i + 1) cfg(0, ofs[i], 4'hF, 32'h0);
        probe(32'h0);
        cfg(1, 8'h2C, 4'hF, 32'hFFFF_1003);
        cfg(1, 8'h30, 4'hF, 32'h0000_103C);
        cfg(1, 8'h38, 4'h3, 32'h0000_07FC);
        for (i = 0; i < 8; i = i + 1) probe(bnd[i]);
        repeat (4) begin
            for (i = 0; i < 8; i = i + 1) cfg(0, ofs[i], 4'hF, 32'h0);
            repeat (40) probe($urandom & 32'h0001_13FC);
            repeat (12) begin
                r = $urandom;
                cfg(r[0], ofs[r[3:1]], r[7:4], $urandom);
            end
        end
        close_out;
    end
    initial begin
        #100000;
        error_cnt = error_cnt + 1;
        close_out;
    end
endmodule
bind iowd_decode_regs iowd_chk i_chk (.i_mclk, .i_rst_n, .i_cfg_wr, .i_cfg_rd, .i_cfg_addr,
    .o_cfg_rdata, .i_pci_io_addr, .o_cfg_ack, .i_pci_io_req, .o_fwd_to_cb,
    .i_legacy_io_alias_filter, .i_functional_irq_route_select, .i_card_func_irq,
    .o_pci_inta, .o_legacy_irq);
